// file: src/djk_defs.vh
`ifndef DJK_DEFS_VH
`define DJK_DEFS_VH

// number of independent flip-flop slices
`define DJK_SLICES      2
// stored state and outputs after rst
`define DJK_STATE_RST   1'h0
`define DJK_TRUE_RST    1'h0
`define DJK_COMP_RST    1'h1
// edge detector history after rst
`define DJK_CLK_HIST_RST 1'h0

`endif

// file: src/djk_edge.v
`timescale 1ns/10ps
`default_nettype none
`include "djk_defs.vh"

module djk_edge (
    // clock and reset
    input  wire core_clk,
    input  wire rst,
    // sampled pin and its rising edge
    input  wire pin,
    output wire rise
);

    reg prev;

    always @(posedge core_clk) begin
        if (rst) begin
            prev <= `DJK_CLK_HIST_RST;
        end else begin
            prev <= pin;
        end
    end

    // history starts low, so a pin already high at release counts as one edge
    assign rise = pin & ~prev;

endmodule
`default_nettype wire

// file: src/djk_dual.v
`timescale 1ns/10ps
`default_nettype none
`include "djk_defs.vh"

module djk_dual (
    // clock and reset
    input  wire                      core_clk,
    input  wire                      rst,
    // per slice clock and data
    input  wire [`DJK_SLICES-1:0]    ff_clk,
    input  wire [`DJK_SLICES-1:0]    set_in,
    input  wire [`DJK_SLICES-1:0]    keep_n,
    // per slice asynchronous controls
    input  wire [`DJK_SLICES-1:0]    async_one_n,
    input  wire [`DJK_SLICES-1:0]    async_zero_n,
    // per slice outputs
    output reg  [`DJK_SLICES-1:0]    q,
    output reg  [`DJK_SLICES-1:0]    q_n
);

    // control modes; both low outranks either control alone
    localparam [1:0] CTL_RUN  = 2'h0;
    localparam [1:0] CTL_ONE  = 2'h1;
    localparam [1:0] CTL_ZERO = 2'h2;
    localparam [1:0] CTL_BOTH = 2'h3;

    function [1:0] ctl_mode;
        input one_n;
        input zero_n;
        begin
            case ({one_n, zero_n})
                2'h0: begin
                    ctl_mode = CTL_BOTH;
                end
                2'h1: begin
                    ctl_mode = CTL_ONE;
                end
                2'h2: begin
                    ctl_mode = CTL_ZERO;
                end
                default: begin
                    ctl_mode = CTL_RUN;
                end
            endcase
        end
    endfunction

    // j and the companion input, sampled together on an edge
    function next_state;
        input cur;
        input j;
        input kn;
        begin
            case ({j, kn})
                2'h0: begin
                    next_state = 1'h0;
                end
                2'h1: begin
                    next_state = cur;
                end
                2'h2: begin
                    next_state = ~cur;
                end
                default: begin
                    next_state = 1'h1;
                end
            endcase
        end
    endfunction

    // true output level in each control mode
    function true_level;
        input [1:0] mode;
        input       st;
        begin
            case (mode)
                CTL_RUN: begin
                    true_level = st;
                end
                CTL_ONE: begin
                    true_level = 1'h1;
                end
                CTL_ZERO: begin
                    true_level = 1'h0;
                end
                CTL_BOTH: begin
                    true_level = 1'h1;
                end
                default: begin
                    true_level = st;
                end
            endcase
        end
    endfunction

    // both outputs high while both controls are low, so not a plain inverse
    function comp_level;
        input [1:0] mode;
        input       st;
        begin
            case (mode)
                CTL_RUN: begin
                    comp_level = ~st;
                end
                CTL_ONE: begin
                    comp_level = 1'h0;
                end
                CTL_ZERO: begin
                    comp_level = 1'h1;
                end
                CTL_BOTH: begin
                    comp_level = 1'h1;
                end
                default: begin
                    comp_level = ~st;
                end
            endcase
        end
    endfunction

    // stored bit apart from the outputs, so the both-low pattern can end
    reg  [`DJK_SLICES-1:0] state;
    wire [`DJK_SLICES-1:0] rise;

    genvar i;

    generate
        // one slice per flip-flop; slices share only core_clk and rst
        for (i = 0; i < `DJK_SLICES; i = i + 1) begin : g_slice
            wire [1:0] mode;
            wire       loaded;
            reg        next_st;
            reg        next_q;
            reg        next_q_n;

            // a slice clock already high at release counts as one edge
            djk_edge u_edge (
                .core_clk (core_clk),
                .rst      (rst),
                .pin      (ff_clk[i]),
                .rise     (rise[i])
            );

            assign mode   = ctl_mode(async_one_n[i], async_zero_n[i]);
            assign loaded = next_state(state[i], set_in[i], keep_n[i]);

            // an edge seen while a control is low is dropped, not held over
            always @* begin
                next_st = state[i];
                case (mode)
                    CTL_RUN: begin
                        if (rise[i]) begin
                            next_st = loaded;
                        end
                    end
                    CTL_ONE: begin
                        next_st = 1'h1;
                    end
                    CTL_ZERO: begin
                        next_st = 1'h0;
                    end
                    CTL_BOTH: begin
                        // kept so a joint release falls back to it
                        next_st = state[i];
                    end
                    default: begin
                        next_st = state[i];
                    end
                endcase
            end

            // true output next value
            always @* begin
                next_q = true_level(mode, next_st);
            end

            // complement output next value
            always @* begin
                next_q_n = comp_level(mode, next_st);
            end

            // controls act one core_clk later; not truly asynchronous
            always @(posedge core_clk) begin
                if (rst) begin
                    state[i] <= `DJK_STATE_RST;
                end else begin
                    state[i] <= next_st;
                end
            end

            // true output, straight from its flip-flop
            always @(posedge core_clk) begin
                if (rst) begin
                    q[i] <= `DJK_TRUE_RST;
                end else begin
                    q[i] <= next_q;
                end
            end

            // complement output, straight from its flip-flop
            always @(posedge core_clk) begin
                if (rst) begin
                    q_n[i] <= `DJK_COMP_RST;
                end else begin
                    q_n[i] <= next_q_n;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// file: dv/djk_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "djk_defs.vh"
module djk_checker (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   rst,
    // slice inputs
    input wire logic [`DJK_SLICES-1:0] ff_clk,
    input wire logic [`DJK_SLICES-1:0] set_in,
    input wire logic [`DJK_SLICES-1:0] keep_n,
    input wire logic [`DJK_SLICES-1:0] async_one_n,
    input wire logic [`DJK_SLICES-1:0] async_zero_n,
    // slice outputs
    input wire logic [`DJK_SLICES-1:0] q,
    input wire logic [`DJK_SLICES-1:0] q_n
);
    reg  h, p;
    wire ok   = async_one_n[0] & async_zero_n[0];
    wire rise = ff_clk[0] & ~h;
    // history mirrors the slice edge detector, so the first edge after rst agrees
    always @(posedge core_clk) begin
        h <= ~rst & ff_clk[0];
        p <= rst | ok;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_both_low; !async_one_n[0] && !async_zero_n[0]; endsequence
    sequence s_joint_release; s_both_low ##1 ok; endsequence
    a_preset_sets: assert property (
        !async_one_n[0] && async_zero_n[0] |=> q[0] && !q_n[0])
        else $error("preset");
    a_clear_resets: assert property (
        async_one_n[0] && !async_zero_n[0] |=> !q[0] && q_n[0])
        else $error("clear");
    a_both_low_high: assert property (s_both_low |=> q[0] && q_n[0])
        else $error("both");
    a_both_release: assert property (s_joint_release |=> q[0] != q_n[0])
        else $error("release");
    a_hold_no_edge: assert property (
        ok && p && !rise |=> $stable(q[0]) && $stable(q_n[0]))
        else $error("hold");
    a_toggle_state: assert property (
        ok && p && rise && set_in[0] && !keep_n[0] |=> q[0] != $past(q[0]))
        else $error("toggle");
    a_load_equal: assert property (
        ok && rise && set_in[0] == keep_n[0] |=> q[0] == $past(set_in[0]) && q_n[0] != q[0])
        else $error("load");
    a_slice_apart: assert property (
        async_one_n[1] && !async_zero_n[1] |=> !q[1] && q_n[1])
        else $error("slice");
endmodule
bind djk_dual djk_checker djk_checker_inst (.core_clk, .rst, .ff_clk, .set_in, .keep_n,
    .async_one_n, .async_zero_n, .q, .q_n);
`default_nettype wire

// file: dv/djk_drive.sv
`timescale 1ns/10ps
`default_nettype none
module djk_drive (
    // random word from the bench
    input  wire logic [31:0] r,
    // slice inputs of the flip-flops
    output wire logic [1:0]  ff_clk,
    output wire logic [1:0]  set_in,
    output wire logic [1:0]  keep_n,
    output wire logic [1:0]  one_n,
    output wire logic [1:0]  zero_n
);
    // controls low one time in four, so clocked traffic dominates
    assign {set_in, keep_n, ff_clk} = r[5:0];
    assign one_n  = r[7:6] | r[9:8];
    assign zero_n = r[11:10] | r[13:12];
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        core_clk = 0, rst = 1;
    logic [31:0] r = 0;
    logic [1:0]  ck, j, kn, pn, cn, q, q_n, st, eq, eqn, h;
    integer      fail_count = 0, total_checks = 0, n;
    djk_drive djk_drive_inst (.r, .ff_clk(ck), .set_in(j), .keep_n(kn), .one_n(pn), .zero_n(cn));
    djk_dual djk_dual_inst (.core_clk, .rst, .ff_clk(ck), .set_in(j), .keep_n(kn),
        .async_one_n(pn), .async_zero_n(cn), .q, .q_n);
    function automatic logic [1:0] nx(logic [1:0] s, e);
        nx = e & (j & (kn | ~s) | ~j & kn & s) | ~e & s;
        nx = (nx | ~pn & cn) & ~(pn & ~cn);
    endfunction
    task results;
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        st = rst ? 2'h0 : nx(st, ck & ~h & pn & cn);
        h = rst ? 2'h0 : ck;
        eq = rst ? 2'h0 : st | ~(pn | cn);
        eqn = rst ? 2'h3 : ~st | ~(pn | cn);
    end
    always @(negedge core_clk) if (!rst) begin
        total_checks++;
        if ({q, q_n} !== {eq, eqn}) begin
            $display("unexpected q,q_n exp %h seen %h", {eq, eqn}, {q, q_n});
            fail_count++;
        end
    end
    initial forever #25 core_clk = ~core_clk;
    initial begin
        void'($urandom(97844));
        repeat (12) @(negedge core_clk);
        rst <= 0;
        // both controls low, then both released together with no edge
        for (n = 0; n < 3000; n++) begin
            @(negedge core_clk);
            r <= n < 2 ? 32'h0000_3FC0 * n : $urandom;
        end
        results;
    end
    initial begin
        #300000;
        fail_count++;
        results;
    end
endmodule
`default_nettype wire
